/* File: hdl/pap_pkg.sv */
// Constants, field layouts and the checksum step for the parallel readout port
package pap_pkg;

  // ==========================================================================
  // Register map
  localparam logic [6:0] PAP_OFS_INTERFACE_SETTINGS = 7'h02;
  localparam logic [6:0] PAP_OFS_CHECKSUM_CTRL      = 7'h21;
  localparam logic [6:0] PAP_OFS_FAULT_STATUS       = 7'h22;
  localparam logic [7:0] PAP_RST_INTERFACE_SETTINGS = 8'h00;
  localparam logic [7:0] PAP_RST_CHECKSUM_CTRL      = 8'h00;
  localparam int         PAP_BIT_STATUS_EN          = 6;
  localparam int         PAP_BIT_CHECKSUM_EN        = 2;

  // ==========================================================================
  // Command word fields
  localparam int         PAP_CMD_RD_BIT             = 15;
  localparam int         PAP_CMD_ADDR_MSB           = 14;
  localparam int         PAP_CMD_ADDR_LSB           = 8;

  // ==========================================================================
  // Stream geometry
  localparam int         PAP_CHANNELS               = 8;
  localparam int         PAP_WORD_W                 = 16;
  localparam int         PAP_FIFO_DEPTH             = 8;
  localparam logic [15:0] PAP_CRC_POLY              = 16'h1021;
  localparam logic [15:0] PAP_CRC_SEED              = 16'hffff;

  typedef enum logic [2:0]
  {
    PAP_GEN_IDLE   = 3'b000,
    PAP_GEN_DATA   = 3'b001,
    PAP_GEN_STATUS = 3'b010,
    PAP_GEN_CSUM   = 3'b011,
    PAP_GEN_DONE   = 3'b100
  } pap_gen_e;

  // One word folded into the running checksum, MSB first
  function automatic logic [15:0] pap_crc_step(input logic [15:0] crc, input logic [15:0] word);
    logic [15:0] r;
    logic        fb;
    r = crc;
    for (int i = 15; i >= 0; i--)
    begin
      fb = r[15] ^ word[i];
      r  = {r[14:0], 1'b0};
      if (fb)
      begin
        r = r ^ PAP_CRC_POLY;
      end
    end
    return r;
  endfunction : pap_crc_step

endpackage : pap_pkg

/* File: hdl/pap_stream_if.sv */
// Valid/ready word stream between the frame generator and the FIFO stages
`timescale 1ns/10ps
interface pap_stream_if #(parameter int W = 17);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : pap_stream_if

/* File: hdl/pap_sync.sv */
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/10ps
module pap_sync
  import pap_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,   // System clock
  input  wire logic         rst_b, // Async reset, active low
  input  wire logic [W-1:0] din,   // Asynchronous pin levels
  output logic      [W-1:0] dout   // Synchronised levels
);

  logic [W-1:0] meta_q;

  // ==========================================================================
  // One pair of flops per bit; pins idle high so reset to ones
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta_q[g] <= 1'b1;
          dout[g]   <= 1'b1;
        end
        else
        begin
          meta_q[g] <= din[g];
          dout[g]   <= meta_q[g];
        end
      end
    end
  endgenerate

endmodule : pap_sync

/* File: hdl/pap_fifo.sv */
// Small show-ahead FIFO with flush, valid/ready on both sides
`timescale 1ns/10ps
module pap_fifo
  import pap_pkg::*;
#(
  parameter int W     = 17,
  parameter int DEPTH = PAP_FIFO_DEPTH
)
(
  input  wire logic   clk,   // System clock
  input  wire logic   rst_b, // Async reset, active low
  input  wire logic   flush, // Drop all stored words
  pap_stream_if.snk   wr_s,  // Filling side
  pap_stream_if.src   rd_s   // Draining side
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  assign empty      = (wp_q == rp_q);
  assign full       = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign wr_s.ready = !full && !flush;
  assign rd_s.valid = !empty;
  assign rd_s.data  = mem[rp_q[AW-1:0]];
  assign push       = wr_s.valid && wr_s.ready;
  assign pop        = rd_s.valid && rd_s.ready && !flush;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wp_q[AW-1:0]] <= wr_s.data;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else if (flush)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop)
      begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

endmodule : pap_fifo

/* File: hdl/pap_port.sv */
// Parallel host port: ADC result readout and register access over a 16-bit strobed bus
//
// Contract
// [R1] Each read strobe fall presents the next result, first channel to eighth.
// [R2] Chip select may stay low; read strobe alone fetches results.
// [R3] Shared chip select/read fall enables the bus and presents the next word.
// [R4] New results readable after busy falls; earlier set readable while busy high.
// [R5] Output result registers load exactly at the busy falling edge.
// [R6] Host completes busy-high reads before busy falls, never reads on it.
// [R7] First-channel flag floats while chip select high, driven after it falls.
// [R8] First-channel flag high on first result read, low after the next read.
// [R9] Checksum enable bit adds one 16-bit checksum word after all channels.
// [R10] Checksum covers every driven word: data, headers and zero low bytes.
// [R11] Status enable bit gives each channel a result frame then a header frame.
// [R12] Header on upper byte, bit 15 its MSB; lower byte zeros.
// [R13] Header: reset seen, digital fault, input open, two reserved, channel index.
// [R14] Channel index is channel number minus one, in binary.
// [R15] Register mode drives the bus only while select and a strobe are low.
// [R16] Read command: bit 15 set, address 14..8, low byte ignored; enters register mode.
// [R17] Command word and address captured on write strobe rising edge.
// [R18] Read after command returns bit 15 low, address, then register contents.
// [R19] An all-zero write frame returns to ADC mode; no results in register mode.
// [R20] Register write: bit 15 clear, address 14..8, data 7..0.
// [R21] Register write data latched on write strobe rising edge.
// [R22] Host reads any register before writing a sequence of registers.
// [R23] Parallel port active only while interface select is low.
// [R24] Chip select rising floats the bus, its falling edge enables drivers.
// [R25] Reserved header bits are always driven zero.
`timescale 1ns/10ps
module pap_port
  import pap_pkg::*;
#(
  parameter int NCH = PAP_CHANNELS
)
(
  input  wire logic                  clk,                // 250 MHz system clock
  input  wire logic                  rst_b,              // Async reset, active low
  input  wire logic                  cs_b,               // Chip select pin, active low
  input  wire logic                  rd_b,               // Read strobe pin, active low
  input  wire logic                  wr_b,               // Write strobe pin, active low
  input  wire logic                  busy,               // Conversion in progress pin
  input  wire logic                  interface_select,   // Low selects parallel port
  input  wire logic                  software_mode,      // High when mode straps select software
  input  wire logic [15:0]           parallel_bus_in,    // Bus level seen at the pins
  output logic      [15:0]           parallel_bus_out,   // Bus drive value
  output logic                       parallel_bus_oe,    // High while driving the bus
  output logic                       first_channel_flag, // First-channel indicator value
  output logic                       first_channel_oe,   // High while driving the indicator
  input  wire logic [NCH*16-1:0]     conv_results,       // Core results, channel 0 in low bits
  input  wire logic                  reset_seen,         // Core reset-detected flag
  input  wire logic [7:0]            fault_status,       // Core digital fault register
  input  wire logic [NCH-1:0]        input_open,         // Per-channel open input flags
  output logic      [7:0]            interface_settings  // Settings register to the core
);

  localparam int SW = 6 + 16;
  localparam int FW = 17;

  // ==========================================================================
  // Pin synchronisation
  logic [SW-1:0] pin_s;
  logic          cs_s;
  logic          rd_s;
  logic          wr_s;
  logic          idle_s;
  logic          isel_s;
  logic          swm_s;
  logic [15:0]   bus_s;

  pap_sync #(.W(SW)) u_sync
  (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({cs_b, rd_b, wr_b, !busy, interface_select, software_mode, parallel_bus_in}),
    .dout  (pin_s)
  );

  assign {cs_s, rd_s, wr_s, idle_s, isel_s, swm_s, bus_s} = pin_s;

  // ==========================================================================
  // Edge detection; busy travels inverted so the ones reset reads as idle, not a fall
  logic rd_d1_q;
  logic wr_d1_q;
  logic idle_d1_q;
  logic rd_fall;
  logic wr_rise;
  logic busy_fall;
  logic port_on;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_d1_q   <= 1'b1;
      wr_d1_q   <= 1'b1;
      idle_d1_q <= 1'b1;
    end
    else
    begin
      rd_d1_q   <= rd_s;
      wr_d1_q   <= wr_s;
      idle_d1_q <= idle_s;
    end
  end

  assign port_on   = !isel_s;                                   // [R23]
  assign rd_fall   = rd_d1_q && !rd_s && !cs_s && port_on;       // [R2]
  assign wr_rise   = !wr_d1_q && wr_s && !cs_s && port_on;       // [R17]
  assign busy_fall = !idle_d1_q && idle_s;

  // ==========================================================================
  // Mode and register file
  logic       reg_mode_q;
  logic [6:0] addr_q;
  logic [7:0] settings_q;
  logic [7:0] csum_ctrl_q;
  logic [7:0] reg_val;
  logic       status_en;
  logic       csum_en;

  assign interface_settings = settings_q;
  assign status_en = swm_s && settings_q[PAP_BIT_STATUS_EN];    // [R11]
  assign csum_en   = swm_s && csum_ctrl_q[PAP_BIT_CHECKSUM_EN]; // [R9]

  // Register mode is entered and left only in software mode; there an all-zero frame exits it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_mode_q <= 1'b0;
      addr_q     <= '0;
    end
    else if (wr_rise && swm_s)
    begin
      if (bus_s == '0)
      begin
        reg_mode_q <= 1'b0;                                     // [R19]
      end
      else if (bus_s[PAP_CMD_RD_BIT])
      begin
        reg_mode_q <= 1'b1;                                     // [R16]
        addr_q     <= bus_s[PAP_CMD_ADDR_MSB:PAP_CMD_ADDR_LSB]; // [R17]
      end
    end
  end

  // Writes are accepted in either mode; the all-zero frame writes nothing
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      settings_q  <= PAP_RST_INTERFACE_SETTINGS;
      csum_ctrl_q <= PAP_RST_CHECKSUM_CTRL;
    end
    else if (wr_rise && swm_s && !bus_s[PAP_CMD_RD_BIT] && bus_s != '0)
    begin
      case (bus_s[PAP_CMD_ADDR_MSB:PAP_CMD_ADDR_LSB])           // [R20]
        PAP_OFS_INTERFACE_SETTINGS: settings_q  <= bus_s[7:0];  // [R21]
        PAP_OFS_CHECKSUM_CTRL:      csum_ctrl_q <= bus_s[7:0];  // [R21]
        default:                    ;
      endcase
    end
  end

  always_comb
  begin
    case (addr_q)
      PAP_OFS_INTERFACE_SETTINGS: reg_val = settings_q;
      PAP_OFS_CHECKSUM_CTRL:      reg_val = csum_ctrl_q;
      PAP_OFS_FAULT_STATUS:       reg_val = fault_status;
      default:                    reg_val = 8'h00;
    endcase
  end

  // ==========================================================================
  // Output result registers
  logic [15:0] res_q [NCH];

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_res
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          res_q[g] <= '0;
        end
        else if (busy_fall)
        begin
          res_q[g] <= conv_results[g*16 +: 16];                 // [R5]
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Frame generator
  // Frames are built ahead of the strobes so a read only pops the FIFO; bit 16
  // tags the first channel's result frame for the indicator.
  pap_stream_if #(.W(FW)) gen_s ();
  pap_stream_if #(.W(FW)) out_s ();

  pap_gen_e    st_q;
  logic [2:0]  ch_q;
  logic [15:0] crc_q;
  logic [15:0] gen_word;
  logic [7:0]  header;
  logic        push;
  logic        last_ch;

  assign last_ch = (ch_q == 3'(NCH - 1));
  assign header  = {reset_seen, fault_status != 8'h00, input_open[ch_q],
                    2'b00,                                      // [R25]
                    ch_q};                                      // [R13] [R14]

  always_comb
  begin
    case (st_q)
      PAP_GEN_DATA:   gen_word = res_q[ch_q];                   // [R1]
      PAP_GEN_STATUS: gen_word = {header, 8'h00};               // [R12]
      PAP_GEN_CSUM:   gen_word = crc_q;                         // [R9]
      default:        gen_word = 16'h0000;
    endcase
  end

  assign gen_s.valid = (st_q == PAP_GEN_DATA) || (st_q == PAP_GEN_STATUS)
                       || (st_q == PAP_GEN_CSUM);
  assign gen_s.data  = {(st_q == PAP_GEN_DATA) && (ch_q == 3'd0), gen_word};
  assign push        = gen_s.valid && gen_s.ready;

  // A busy fall restarts the sequence from the fresh snapshot
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= PAP_GEN_DATA;
      ch_q <= '0;
    end
    else if (busy_fall)
    begin
      st_q <= PAP_GEN_DATA;                                     // [R4]
      ch_q <= '0;
    end
    else if (push)
    begin
      case (st_q)
        PAP_GEN_DATA:
        begin
          if (status_en)
          begin
            st_q <= PAP_GEN_STATUS;                             // [R11]
          end
          else if (!last_ch)
          begin
            ch_q <= ch_q + 3'd1;
          end
          else
          begin
            st_q <= csum_en ? PAP_GEN_CSUM : PAP_GEN_DONE;
          end
        end
        PAP_GEN_STATUS:
        begin
          if (!last_ch)
          begin
            st_q <= PAP_GEN_DATA;
            ch_q <= ch_q + 3'd1;
          end
          else
          begin
            st_q <= csum_en ? PAP_GEN_CSUM : PAP_GEN_DONE;
          end
        end
        PAP_GEN_CSUM: st_q <= PAP_GEN_DONE;
        default:      st_q <= PAP_GEN_DONE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      crc_q <= PAP_CRC_SEED;
    end
    else if (busy_fall)
    begin
      crc_q <= PAP_CRC_SEED;
    end
    else if (push && st_q != PAP_GEN_CSUM)
    begin
      crc_q <= pap_crc_step(crc_q, gen_word);                   // [R10]
    end
  end

  // ==========================================================================
  // Result FIFO
  // Flushed on busy fall so stale frames of the old conversion never leak out
  pap_fifo #(.W(FW), .DEPTH(PAP_FIFO_DEPTH)) u_fifo
  (
    .clk   (clk),
    .rst_b (rst_b),
    .flush (busy_fall),
    .wr_s  (gen_s),
    .rd_s  (out_s)
  );

  assign out_s.ready = rd_fall && !reg_mode_q;                  // [R19]

  // ==========================================================================
  // Pin drivers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      parallel_bus_out <= '0;
    end
    else if (rd_fall && reg_mode_q)
    begin
      parallel_bus_out <= {1'b0, addr_q, reg_val};              // [R18]
    end
    else if (rd_fall && out_s.valid && !busy_fall)
    begin
      parallel_bus_out <= out_s.data[15:0];                     // [R1] [R3]
    end
  end

  // A read past the end of the sequence repeats the last word on the bus
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      first_channel_flag <= 1'b0;
    end
    else if (rd_fall && !reg_mode_q && !busy_fall)
    begin
      first_channel_flag <= out_s.valid && out_s.data[16];      // [R8]
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      parallel_bus_oe <= 1'b0;
    end
    else if (reg_mode_q)
    begin
      // Only the read phase drives; the host owns the bus during writes
      parallel_bus_oe <= port_on && !cs_s && !rd_s;             // [R15]
    end
    else
    begin
      parallel_bus_oe <= port_on && !cs_s && wr_s;              // [R24] [R3]
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      first_channel_oe <= 1'b0;
    end
    else
    begin
      first_channel_oe <= port_on && !cs_s;                     // [R7]
    end
  end

endmodule : pap_port

/* File: verif/pap_port_assertions.sv */
// Concurrent checks on the pins of the parallel readout port
`timescale 1ns/10ps
module pap_port_checker (
  input wire logic        clk,                // System clock
  input wire logic        rst_b,              // Async reset, active low
  input wire logic        cs_b,               // Chip select, active low
  input wire logic        rd_b,               // Read strobe, active low
  input wire logic        wr_b,               // Write strobe, active low
  input wire logic        interface_select,   // Low selects parallel port
  input wire logic [15:0] parallel_bus_out,   // Bus drive value
  input wire logic        parallel_bus_oe,    // Bus drive enable
  input wire logic        first_channel_flag, // Indicator value
  input wire logic        first_channel_oe,   // Indicator drive enable
  input wire logic [7:0]  interface_settings  // Settings register
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Output enables; the repetition counts cover the pin synchroniser latency
  a_bus_float_cs: assert property (cs_b [*4] |-> !parallel_bus_oe)
    else $error("bus driven while chip select high");
  a_flag_float_cs: assert property (cs_b [*4] |-> !first_channel_oe)
    else $error("indicator driven while chip select high");
  a_serial_bus_off: assert property (interface_select [*4] |-> !parallel_bus_oe)
    else $error("bus driven with serial interface selected");
  a_serial_flag_off: assert property (interface_select [*4] |-> !first_channel_oe)
    else $error("indicator driven with serial interface selected");
  a_flag_drive_on: assert property ((!cs_b && !interface_select) [*5] |-> first_channel_oe)
    else $error("indicator not driven after chip select fell");

  // ==========================================================================
  // Values move only on their strobes
  a_flag_hold_idle: assert property (rd_b [*6] |-> $stable(first_channel_flag))
    else $error("indicator moved without a read strobe");
  a_bus_hold_idle: assert property ((rd_b && wr_b) [*6] |-> $stable(parallel_bus_out))
    else $error("bus word moved without a read strobe");
  a_settings_hold: assert property (wr_b [*6] |-> $stable(interface_settings))
    else $error("settings changed without a write strobe");

  c_flag_rise: cover property ($rose(first_channel_flag));
  c_settings_write: cover property ($changed(interface_settings));
  c_bus_enable: cover property ($rose(parallel_bus_oe));
endmodule : pap_port_checker

/* File: verif/pap_host_model.sv */
// Behavioural host bus controller driving the parallel port strobes
`timescale 1ns/10ps
module pap_host_model (
  input  wire logic        clk,       // System clock
  input  wire logic [15:0] dev_out,   // Device bus drive value
  input  wire logic        dev_oe,    // Device drives the bus
  output logic             cs_b,      // Chip select, active low
  output logic             rd_b,      // Read strobe, active low
  output logic             wr_b,      // Write strobe, active low
  output logic      [15:0] bus_level  // Resolved bus level
);
  logic [15:0] host_data;
  logic        host_oe;
  logic        tie_cs_rd;
  logic [15:0] last_q;

  initial
  begin
    cs_b = 1'b1;
    rd_b = 1'b1;
    wr_b = 1'b1;
    host_oe = 1'b0;
    host_data = 16'h0000;
    tie_cs_rd = 1'b0;
    last_q = 16'h0000;
  end

  // Bus has no pull, so an undriven bus shows a pattern that changes every cycle
  always_comb bus_level = dev_oe ? dev_out : (host_oe ? host_data : ~last_q);
  always @(posedge clk) last_q <= bus_level;

  // ==========================================================================
  // Strobe phases last at least five cycles to clear the device's synchronisers
  task automatic set_cs(input logic v, input logic tie);
    @(negedge clk);
    cs_b = v;
    tie_cs_rd = tie;
    repeat (5) @(negedge clk);
  endtask : set_cs

  task automatic read_word(output logic [15:0] d);
    @(negedge clk);
    rd_b = 1'b0;
    if (tie_cs_rd) cs_b = 1'b0;
    repeat (6) @(posedge clk);
    d = bus_level;
    @(negedge clk);
    rd_b = 1'b1;
    if (tie_cs_rd) cs_b = 1'b1;
    repeat (5) @(negedge clk);
  endtask : read_word

  task automatic write_word(input logic [15:0] v);
    @(negedge clk);
    host_oe = 1'b1;
    host_data = v;
    wr_b = 1'b0;
    repeat (5) @(negedge clk);
    wr_b = 1'b1;
    repeat (4) @(negedge clk);
    host_oe = 1'b0;
    repeat (2) @(negedge clk);
  endtask : write_word
endmodule : pap_host_model

/* File: verif/tb.sv */
// Self-checking bench for the parallel readout port
`timescale 1ns/10ps
module tb;
  import pap_pkg::*;
  logic         clk, rst_b, busy, interface_select, software_mode, reset_seen;
  logic         cs_b, rd_b, wr_b, bus_oe, flag, flag_oe;
  logic [15:0]  bus_level, bus_out, d;
  logic [127:0] conv;
  logic [7:0]   fault, open_f, settings;
  int           num_errors, total_checks;

  always #2 clk = ~clk;

  pap_host_model host (.clk(clk), .dev_out(bus_out), .dev_oe(bus_oe), .cs_b(cs_b),
    .rd_b(rd_b), .wr_b(wr_b), .bus_level(bus_level));

  pap_port #(.NCH(8)) uut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
    .busy(busy), .interface_select(interface_select), .software_mode(software_mode),
    .parallel_bus_in(bus_level), .parallel_bus_out(bus_out), .parallel_bus_oe(bus_oe),
    .first_channel_flag(flag), .first_channel_oe(flag_oe), .conv_results(conv),
    .reset_seen(reset_seen), .fault_status(fault), .input_open(open_f),
    .interface_settings(settings));

  // ==========================================================================
  // Compare and expectation helpers
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : chk1

  function automatic logic [15:0] res(input logic [3:0] k, input logic [3:0] g);
    return {g, k, 8'h3c};
  endfunction : res

  function automatic logic [15:0] hdr(input logic [2:0] k);
    return {reset_seen, |fault, open_f[k], 2'b00, k, 8'h00};
  endfunction : hdr

  function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [15:0] w);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? PAP_CRC_POLY : 16'h0000);
    return c;
  endfunction : crc_next

  // ==========================================================================
  // Conversion and read sequences
  task automatic start_conv(input logic [3:0] g);
    @(negedge clk);
    busy = 1'b1;
    repeat (2) @(negedge clk);
    for (int k = 0; k < 8; k++) conv[16*k +: 16] = res(4'(k), g);
  endtask : start_conv

  task automatic end_conv;
    repeat (4) @(negedge clk);
    busy = 1'b0;
    repeat (12) @(negedge clk);
  endtask : end_conv

  task automatic read_seq(input int lo, input int hi, input logic stat, input logic csum,
                          input logic [3:0] g);
    logic [15:0] crc;
    crc = PAP_CRC_SEED;
    for (int k = lo; k <= hi; k++)
    begin
      host.read_word(d);
      chk16(d, res(4'(k), g));
      chk1(flag, 1'(k == 0));
      crc = crc_next(crc, res(4'(k), g));
      if (stat)
      begin
        host.read_word(d);
        chk16(d, hdr(3'(k)));
        chk1(flag, 1'b0);
        crc = crc_next(crc, hdr(3'(k)));
      end
    end
    if (csum)
    begin
      host.read_word(d);
      chk16(d, crc);
    end
  endtask : read_seq

  task automatic reg_read(input logic [6:0] a, input logic [7:0] v);
    host.write_word({1'b1, a, 8'h00});
    host.read_word(d);
    chk16(d, {1'b0, a, v});
  endtask : reg_read

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    busy = 1'b0;
    interface_select = 1'b0;
    software_mode = 1'b1;
    reset_seen = 1'b1;
    fault = 8'h04;
    open_f = 8'h22;
    conv = '0;
    num_errors = 0;
    total_checks = 0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk1(bus_oe, 1'b0);
    chk1(flag_oe, 1'b0);
    chk16({8'h00, settings}, {8'h00, PAP_RST_INTERFACE_SETTINGS});
    host.set_cs(1'b0, 1'b0);
    chk1(bus_oe, 1'b1);
    chk1(flag_oe, 1'b1);
    start_conv(4'h1);
    end_conv();
    read_seq(0, 3, 1'b0, 1'b0, 4'h1);
    start_conv(4'h2);
    read_seq(4, 7, 1'b0, 1'b0, 4'h1);
    end_conv();
    read_seq(0, 7, 1'b0, 1'b0, 4'h2);
    reg_read(PAP_OFS_INTERFACE_SETTINGS, PAP_RST_INTERFACE_SETTINGS);
    chk1(bus_oe, 1'b0);
    reg_read(PAP_OFS_CHECKSUM_CTRL, PAP_RST_CHECKSUM_CTRL);
    reg_read(PAP_OFS_FAULT_STATUS, fault);
    host.write_word({1'b0, PAP_OFS_INTERFACE_SETTINGS, 8'h40});
    chk16({8'h00, settings}, 16'h0040);
    software_mode = 1'b0;
    host.write_word({1'b0, PAP_OFS_INTERFACE_SETTINGS, 8'h11});
    chk16({8'h00, settings}, 16'h0040);
    software_mode = 1'b1;
    host.write_word({1'b0, PAP_OFS_CHECKSUM_CTRL, 8'h04});
    host.write_word({1'b0, 7'h7f, 8'hff});
    reg_read(PAP_OFS_INTERFACE_SETTINGS, 8'h40);
    reg_read(PAP_OFS_CHECKSUM_CTRL, 8'h04);
    reg_read(7'h7f, 8'h00);
    host.write_word(16'h0000);
    start_conv(4'h3);
    end_conv();
    read_seq(0, 7, 1'b1, 1'b1, 4'h3);
    host.set_cs(1'b1, 1'b1);
    chk1(bus_oe, 1'b0);
    start_conv(4'h4);
    end_conv();
    read_seq(0, 0, 1'b1, 1'b0, 4'h4);
    chk1(bus_oe, 1'b0);
    interface_select = 1'b1;
    host.set_cs(1'b0, 1'b0);
    chk1(bus_oe, 1'b0);
    chk1(flag_oe, 1'b0);
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule : tb

bind pap_port pap_port_checker u_chk (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b),
  .wr_b(wr_b), .interface_select(interface_select), .parallel_bus_out(parallel_bus_out),
  .parallel_bus_oe(parallel_bus_oe), .first_channel_flag(first_channel_flag),
  .first_channel_oe(first_channel_oe), .interface_settings(interface_settings));
